// ==== logic/usp_pkg.sv ====
// usp_pkg: register map, field positions, reset values and timing counts
// for the serial port; shared by the port top and its receive queue.
package usp_pkg;
   // register byte offsets (one aligned 32-bit word each)
   localparam logic [7:0] USP_OFS_CTRL = 8'h00;
   localparam logic [7:0] USP_OFS_STAT = 8'h04;
   localparam logic [7:0] USP_OFS_TXDATA = 8'h08;
   localparam logic [7:0] USP_OFS_RXDATA = 8'h0c;
   localparam logic [7:0] USP_OFS_BAUD = 8'h10;
   localparam logic [7:0] USP_OFS_RTSLVL = 8'h14;

   // control fields
   localparam int USP_CTRL_TX_EN = 0;
   localparam int USP_CTRL_RX_EN = 1;
   localparam int USP_CTRL_LOOP = 2;
   localparam int USP_CTRL_CTS_EN = 3;
   localparam int USP_CTRL_STOP2 = 4;
   localparam int USP_CTRL_SLEEP = 5;
   localparam int USP_CTRL_RTS_MAN = 6;
   localparam int USP_CTRL_RTS_MODE = 8;
   localparam int USP_CTRL_W = 10;
   localparam logic [9:0] USP_CTRL_RST = 10'h008;

   // status fields
   localparam int USP_STAT_TX_BUSY = 0;
   localparam int USP_STAT_TX_FULL = 1;
   localparam int USP_STAT_RX_AVAIL = 2;
   localparam int USP_STAT_RX_FULL = 3;
   localparam int USP_STAT_OVERRUN = 4;
   localparam int USP_STAT_FRAME = 5;
   localparam int USP_STAT_ASLEEP = 6;
   localparam int USP_STAT_CTS = 7;
   localparam int USP_STAT_COUNT = 8;

   // request-to-send modes
   localparam logic [1:0] USP_RTS_MANUAL = 2'h0;
   localparam logic [1:0] USP_RTS_TX_AUTO = 2'h1;
   localparam logic [1:0] USP_RTS_RX_LEVEL = 2'h2;

   // timing: 16 ticks per bit; serial clock high in phases 0..7
   localparam logic [3:0] USP_FALL_PHASE = 4'h7;
   localparam logic [3:0] USP_MID_PHASE = 4'h7;
   localparam logic [15:0] USP_BAUD_RST = 16'h0043;
   localparam logic [7:0] USP_RTSLVL_RST = 8'h0c;
endpackage

// ==== logic/usp_rx_queue.sv ====
// usp_rx_queue: receive queue, a first-in first-out store of characters.
// assumes one clock; push is ignored while full, pop ignored while empty.
`timescale 1ns/1ps
module usp_rx_queue import usp_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // fill side
   input wire logic i_push,
   input wire logic [WIDTH-1:0] i_push_data,
   output logic o_ready,
   // drain side
   input wire logic i_pop,
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   output logic [AW:0] o_count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   assign o_ready = (count_r < (AW+1)'(DEPTH));
   assign o_valid = (count_r != '0);
   assign o_data = mem[rd_ptr_r];
   assign o_count = count_r;
   assign do_push = i_push && o_ready;
   assign do_pop = i_pop && o_valid;

   always_ff @(posedge i_core_clk) begin
      if (do_push) begin
         mem[wr_ptr_r] <= i_push_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ==== logic/usp_uart.sv ====
// usp_uart: asynchronous serial port with APB registers, transmit holding
// register, receive queue, clear-to-send gating and request-to-send control.
// assumes a 125 MHz core clock; serial pins are asynchronous to it.
//
// Behaviour
// R1: transmit line high when disabled, idle, looped
// R2: transmit LSB first on serial clock fall
// R3: receive assembles bits LSB first
// R4: receive line transition wakes stopped port clock
// R5: clear-to-send grants permission to start sending
// R6: request-to-send driven automatically by hardware
// R7: request-to-send may follow receive queue level
// R8: frame: one low start, high stop bits
`timescale 1ns/1ps
module usp_uart import usp_pkg::*; #(
   parameter int DATA_W = 8,
   parameter int QDEPTH = 16,
   parameter int QAW = 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   // serial pins
   output logic o_serial_tx_out,
   input wire logic i_serial_rx_in,
   input wire logic i_clear_to_send_in_b,
   output logic o_request_to_send_out_b
);
   typedef enum logic [1:0] {USP_TX_IDLE, USP_TX_START, USP_TX_DATA,
      USP_TX_STOP} usp_tx_state_t;
   typedef enum logic [1:0] {USP_RX_IDLE, USP_RX_START, USP_RX_DATA,
      USP_RX_STOP} usp_rx_state_t;

   logic [USP_CTRL_W-1:0] ctrl_r;
   logic [15:0] baud_r;
   logic [7:0] rtslvl_r;
   logic [15:0] div_cnt_r;
   logic tick;
   logic asleep_r;
   logic overrun_r;
   logic frame_r;
   // bus
   logic acc;
   logic wr_fire;
   logic rd_fire;
   logic mapped;
   logic [31:0] rd_val;
   // transmit
   usp_tx_state_t tx_state_r;
   logic [3:0] tx_phase_r;
   logic [DATA_W-1:0] thr_r;
   logic thr_full_r;
   logic [DATA_W-1:0] tx_shift_r;
   logic [3:0] tx_bit_r;
   logic tx_stop2_r;
   logic tx_line_r;
   logic tx_fall;
   logic cts_ok;
   // receive
   logic [2:0] rx_sync_r;
   logic rx_level_r;
   logic [2:0] cts_sync_r;
   logic cts_level_r;
   logic rx_src;
   logic rx_src_d_r;
   usp_rx_state_t rx_state_r;
   logic [3:0] rx_phase_r;
   logic [DATA_W-1:0] rx_shift_r;
   logic [3:0] rx_bit_r;
   logic rx_push;
   logic q_ready;
   logic q_valid;
   logic [DATA_W-1:0] q_data;
   logic [QAW:0] q_count;
   logic rx_edge;

   // one-wait-state slave answering on the second access cycle; o_pready low
   // during the first lets read data settle from a flop
   assign acc = i_psel && i_penable;
   assign wr_fire = acc && o_pready && i_pwrite;
   assign rd_fire = acc && o_pready && !i_pwrite;
   assign mapped = (i_paddr == USP_OFS_CTRL) || (i_paddr == USP_OFS_STAT) ||
      (i_paddr == USP_OFS_TXDATA) || (i_paddr == USP_OFS_RXDATA) ||
      (i_paddr == USP_OFS_BAUD) || (i_paddr == USP_OFS_RTSLVL);

   always_comb begin
      rd_val = '0;
      case (i_paddr)
         USP_OFS_CTRL: rd_val[USP_CTRL_W-1:0] = ctrl_r;
         USP_OFS_STAT: begin
            rd_val[USP_STAT_TX_BUSY] = (tx_state_r != USP_TX_IDLE);
            rd_val[USP_STAT_TX_FULL] = thr_full_r;
            rd_val[USP_STAT_RX_AVAIL] = q_valid;
            rd_val[USP_STAT_RX_FULL] = !q_ready;
            rd_val[USP_STAT_OVERRUN] = overrun_r;
            rd_val[USP_STAT_FRAME] = frame_r;
            rd_val[USP_STAT_ASLEEP] = asleep_r;
            rd_val[USP_STAT_CTS] = cts_level_r;
            rd_val[USP_STAT_COUNT +: QAW+1] = q_count;
         end
         USP_OFS_RXDATA: rd_val[DATA_W-1:0] = q_data;
         USP_OFS_BAUD: rd_val[15:0] = baud_r;
         USP_OFS_RTSLVL: rd_val[7:0] = rtslvl_r;
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= acc && !o_pready;
         o_pslverr <= acc && !o_pready && !mapped;
         if (acc && !o_pready) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : rd_val;
         end
      end
   end

   // software registers
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_r <= USP_CTRL_RST;
         baud_r <= USP_BAUD_RST;
         rtslvl_r <= USP_RTSLVL_RST;
      end else if (wr_fire) begin
         if (i_paddr == USP_OFS_CTRL) ctrl_r <= i_pwdata[USP_CTRL_W-1:0];
         if (i_paddr == USP_OFS_BAUD) baud_r <= i_pwdata[15:0];
         if (i_paddr == USP_OFS_RTSLVL) rtslvl_r <= i_pwdata[7:0];
      end
   end

   // sticky errors: write one to clear, a new event wins over the clear
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         overrun_r <= 1'b0;
         frame_r <= 1'b0;
      end else begin
         if (rx_push && !q_ready) begin
            overrun_r <= 1'b1;
         end else if (wr_fire && i_paddr == USP_OFS_STAT &&
               i_pwdata[USP_STAT_OVERRUN]) begin
            overrun_r <= 1'b0;
         end
         if (rx_state_r == USP_RX_STOP && tick &&
               rx_phase_r == USP_MID_PHASE && !rx_src) begin
            frame_r <= 1'b1;
         end else if (wr_fire && i_paddr == USP_OFS_STAT &&
               i_pwdata[USP_STAT_FRAME]) begin
            frame_r <= 1'b0;
         end
      end
   end

   // pin synchronisers: three flops, level taken once stages 2 and 3 agree
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_sync_r <= 3'h7;
         rx_level_r <= 1'b1;
         cts_sync_r <= 3'h7;
         cts_level_r <= 1'b0;
      end else begin
         rx_sync_r <= {rx_sync_r[1:0], i_serial_rx_in};
         cts_sync_r <= {cts_sync_r[1:0], i_clear_to_send_in_b};
         if (rx_sync_r[1] == rx_sync_r[2]) rx_level_r <= rx_sync_r[2];
         if (cts_sync_r[1] == cts_sync_r[2]) cts_level_r <= !cts_sync_r[2];
      end
   end

   assign rx_src = ctrl_r[USP_CTRL_LOOP] ? tx_line_r : rx_level_r;
   assign rx_edge = (rx_level_r != rx_src_d_r);

   // power-down: the bit-rate engine halts while asleep
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         asleep_r <= 1'b0;
         rx_src_d_r <= 1'b1;
      end else begin
         rx_src_d_r <= rx_level_r;
         if (asleep_r && rx_edge) begin
            asleep_r <= 1'b0; // [R4]
         end else if (wr_fire && i_paddr == USP_OFS_CTRL) begin
            asleep_r <= i_pwdata[USP_CTRL_SLEEP];
         end
      end
   end

   // 16x bit-rate tick; divisor zero treated as one
   assign tick = !asleep_r && (div_cnt_r == '0);
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_cnt_r <= '0;
      end else if (!asleep_r) begin
         div_cnt_r <= (div_cnt_r == '0) ?
            ((baud_r == '0) ? '0 : baud_r - 1'b1) : div_cnt_r - 1'b1;
      end
   end

   // transmit: serial clock is high in phases 0..7, falls entering 8
   assign tx_fall = tick && (tx_phase_r == USP_FALL_PHASE);
   assign cts_ok = !ctrl_r[USP_CTRL_CTS_EN] || cts_level_r;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_state_r <= USP_TX_IDLE;
         tx_phase_r <= '0;
         tx_shift_r <= '0;
         tx_bit_r <= '0;
         tx_stop2_r <= 1'b0;
         tx_line_r <= 1'b1;
      end else begin
         if (tick) tx_phase_r <= tx_phase_r + 1'b1;
         if (tx_fall) begin // [R2]
            case (tx_state_r)
               USP_TX_IDLE: begin
                  tx_line_r <= 1'b1; // [R1]
                  if (thr_full_r && cts_ok && ctrl_r[USP_CTRL_TX_EN]) begin
                     tx_shift_r <= thr_r; // [R5]
                     tx_line_r <= 1'b0; // [R8]
                     tx_state_r <= USP_TX_START;
                  end
               end
               USP_TX_START: begin
                  tx_line_r <= tx_shift_r[0]; // [R2]
                  tx_shift_r <= tx_shift_r >> 1;
                  tx_bit_r <= 4'h1;
                  tx_state_r <= USP_TX_DATA;
               end
               USP_TX_DATA: begin
                  if (tx_bit_r == 4'(DATA_W)) begin
                     tx_line_r <= 1'b1; // [R8]
                     tx_stop2_r <= ctrl_r[USP_CTRL_STOP2];
                     tx_state_r <= USP_TX_STOP;
                  end else begin
                     tx_line_r <= tx_shift_r[0];
                     tx_shift_r <= tx_shift_r >> 1;
                     tx_bit_r <= tx_bit_r + 1'b1;
                  end
               end
               USP_TX_STOP: begin
                  tx_line_r <= 1'b1;
                  if (tx_stop2_r) tx_stop2_r <= 1'b0;
                  else tx_state_r <= USP_TX_IDLE;
               end
               default: tx_state_r <= USP_TX_IDLE;
            endcase
         end
      end
   end

   // holding register: a write while full is dropped
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         thr_r <= '0;
         thr_full_r <= 1'b0;
      end else if (tx_fall && tx_state_r == USP_TX_IDLE && thr_full_r &&
            cts_ok && ctrl_r[USP_CTRL_TX_EN]) begin
         thr_full_r <= 1'b0;
      end else if (wr_fire && i_paddr == USP_OFS_TXDATA && !thr_full_r) begin
         thr_r <= i_pwdata[DATA_W-1:0];
         thr_full_r <= 1'b1;
      end
   end

   // receive: start edge re-centres phase, samples taken mid-bit
   assign rx_push = (rx_state_r == USP_RX_STOP) && tick &&
      (rx_phase_r == USP_MID_PHASE) && rx_src;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_state_r <= USP_RX_IDLE;
         rx_phase_r <= '0;
         rx_shift_r <= '0;
         rx_bit_r <= '0;
      end else begin
         if (tick) rx_phase_r <= rx_phase_r + 1'b1;
         case (rx_state_r)
            USP_RX_IDLE: begin
               if (ctrl_r[USP_CTRL_RX_EN] && !rx_src && !asleep_r) begin
                  rx_phase_r <= '0;
                  rx_state_r <= USP_RX_START;
               end
            end
            USP_RX_START: begin
               if (tick && rx_phase_r == USP_MID_PHASE) begin
                  // a glitch shorter than half a bit is not a start
                  rx_state_r <= rx_src ? USP_RX_IDLE : USP_RX_DATA; // [R8]
                  rx_bit_r <= '0;
               end
            end
            USP_RX_DATA: begin
               if (tick && rx_phase_r == USP_MID_PHASE) begin
                  rx_shift_r <= {rx_src, rx_shift_r[DATA_W-1:1]}; // [R3]
                  rx_bit_r <= rx_bit_r + 1'b1;
                  if (rx_bit_r == 4'(DATA_W - 1)) rx_state_r <= USP_RX_STOP;
               end
            end
            USP_RX_STOP: begin
               if (tick && rx_phase_r == USP_MID_PHASE) begin
                  rx_state_r <= USP_RX_IDLE;
               end
            end
            default: rx_state_r <= USP_RX_IDLE;
         endcase
      end
   end

   usp_rx_queue #(
      .WIDTH(DATA_W),
      .DEPTH(QDEPTH),
      .AW(QAW)
   ) u_receive_queue (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_push(rx_push),
      .i_push_data(rx_shift_r),
      .o_ready(q_ready),
      .i_pop(rd_fire && i_paddr == USP_OFS_RXDATA),
      .o_valid(q_valid),
      .o_data(q_data),
      .o_count(q_count)
   );

   // pins; loopback keeps the line at mark while the receiver hears tx
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_serial_tx_out <= 1'b1;
         o_request_to_send_out_b <= 1'b1;
      end else begin
         o_serial_tx_out <= (ctrl_r[USP_CTRL_LOOP] ||
            !ctrl_r[USP_CTRL_TX_EN]) ? 1'b1 : tx_line_r; // [R1]
         case (ctrl_r[USP_CTRL_RTS_MODE +: 2])
            USP_RTS_TX_AUTO: o_request_to_send_out_b <=
               !(thr_full_r || tx_state_r != USP_TX_IDLE); // [R6]
            USP_RTS_RX_LEVEL: o_request_to_send_out_b <=
               !({{(7-QAW){1'b0}}, q_count} < rtslvl_r); // [R7]
            default: o_request_to_send_out_b <= !ctrl_r[USP_CTRL_RTS_MAN];
         endcase
      end
   end
endmodule

// ==== verif/usp_uart_assertions.sv ====
// usp_uart_assertions: bus and pin checks on the serial port top.
// assumes it is bound to usp_uart and sees only that module's ports.
`timescale 1ns/1ps
module usp_uart_assertions import usp_pkg::*; (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // apb
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [31:0] o_prdata,
   // serial pins
   input wire logic o_serial_tx_out,
   input wire logic i_serial_rx_in,
   input wire logic i_clear_to_send_in_b,
   input wire logic o_request_to_send_out_b
);
   logic [9:0] ctrl_r;
   logic wr_ctrl;
   assign wr_ctrl = o_pready & i_psel & i_penable & i_pwrite
      & (i_paddr == USP_OFS_CTRL);
   // shadow of the control word, so pin checks know the mode
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_r <= USP_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= i_pwdata[9:0];
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   a_tx_off_mark: assert property (
      !ctrl_r[USP_CTRL_TX_EN] && !$past(ctrl_r[USP_CTRL_TX_EN])
      |-> o_serial_tx_out) else $error("tx low while disabled");
   a_tx_loop_mark: assert property (
      ctrl_r[USP_CTRL_LOOP] && $past(ctrl_r[USP_CTRL_LOOP])
      |-> o_serial_tx_out) else $error("tx low in loopback");
   a_cts_gates_start: assert property (
      $fell(o_serial_tx_out) && ctrl_r[USP_CTRL_CTS_EN]
      |-> !$past(i_clear_to_send_in_b)) else $error("tx without cts");
   a_low_bit_width: assert property (
      $fell(o_serial_tx_out) |=> !o_serial_tx_out [*8])
      else $error("low bit too short");
   a_high_bit_width: assert property (
      $rose(o_serial_tx_out) |=> o_serial_tx_out [*8])
      else $error("high bit too short");
   a_rts_manual_level: assert property (
      ctrl_r[9:8] == USP_RTS_MANUAL && $past(ctrl_r) == ctrl_r
      |-> o_request_to_send_out_b == !ctrl_r[USP_CTRL_RTS_MAN])
      else $error("rts not following manual bit");
   a_ready_second_access: assert property (
      $rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
      else $error("pready not in second access cycle");
   a_ready_one_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   a_err_decode: assert property (
      o_pready |-> o_pslverr == (i_paddr > USP_OFS_RTSLVL))
      else $error("pslverr does not match address");
endmodule

// ==== verif/usp_remote_model.sv ====
// usp_remote_model: remote serial terminal facing the port's pins.
// assumes 8 data bits, no parity, BIT_CLKS core clocks per bit.
`timescale 1ns/1ps
module usp_remote_model #(
   parameter int BIT_CLKS = 16
) (
   // clock
   input wire logic i_core_clk,
   // serial lines
   input wire logic i_line_in,
   output logic o_line_out,
   output logic o_cts_b
);
   logic [7:0] got_char;
   logic got_stop;
   int got_cnt;
   initial begin
      o_line_out = 1'b1;
      o_cts_b = 1'b1;
      got_cnt = 0;
      got_char = 8'h00;
      got_stop = 1'b0;
   end
   task set_cts(input logic v);
      @(posedge i_core_clk);
      o_cts_b <= v;
   endtask
   task send_char(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_core_clk);
         o_line_out <= f[i];
         repeat (BIT_CLKS - 1) @(posedge i_core_clk);
      end
   endtask
   // mid-bit sampling; a start gone by then is noise
   always begin
      @(negedge i_line_in);
      repeat (BIT_CLKS / 2) @(posedge i_core_clk);
      if (i_line_in === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge i_core_clk);
            got_char[i] = i_line_in;
         end
         repeat (BIT_CLKS) @(posedge i_core_clk);
         got_stop = i_line_in;
         got_cnt++;
      end
   end
endmodule

// ==== verif/usp_uart_tb_top.sv ====
// usp_uart_tb_top: register and serial-link tests of the serial port.
// assumes baud divisor 0, so one bit is sixteen core clocks.
`timescale 1ns/1ps
module usp_uart_tb_top import usp_pkg::*;;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, tx, rx, cts_b, rts_b, er;
   logic [7:0] pat [2] = '{8'h3c, 8'hc3};
   int errors = 0, samples_checked = 0, cyc = 0;
   always #4 i_core_clk = ~i_core_clk;
   usp_uart i_usp_uart (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_prdata(prdata), .o_serial_tx_out(tx),
      .i_serial_rx_in(rx), .i_clear_to_send_in_b(cts_b),
      .o_request_to_send_out_b(rts_b));
   usp_remote_model #(.BIT_CLKS(16)) i_usp_remote_model (
      .i_core_clk(i_core_clk), .i_line_in(tx), .o_line_out(rx),
      .o_cts_b(cts_b));
   task final_report();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      @(posedge i_core_clk);
      while (pready !== 1'b1) @(posedge i_core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, e,
      input string what);
      apb(1'b0, a, 32'h0);
      check(what, rd & m, e);
   endtask
   task wait_bits(input int n);
      repeat (16 * n) @(posedge i_core_clk);
   endtask
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      @(posedge i_core_clk);
      check("tx idle", {31'h0, tx}, 32'h1);
      rd_chk(USP_OFS_CTRL, 32'h3ff, 32'(USP_CTRL_RST), "ctrl reset");
      rd_chk(USP_OFS_BAUD, 32'hffff, 32'(USP_BAUD_RST), "baud reset");
      rd_chk(USP_OFS_RTSLVL, 32'hff, 32'(USP_RTSLVL_RST), "lvl reset");
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped err", {31'h0, er}, 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, USP_OFS_BAUD, 32'h0);
      $display("test registers done");
      apb(1'b1, USP_OFS_CTRL, 32'h009);
      apb(1'b1, USP_OFS_TXDATA, 32'ha5);
      wait_bits(20);
      check("held by cts", i_usp_remote_model.got_cnt, 0);
      i_usp_remote_model.set_cts(1'b0);
      wait_bits(14);
      check("tx char", i_usp_remote_model.got_char, 32'ha5);
      check("tx stop", i_usp_remote_model.got_stop, 32'h1);
      $display("test transmit done");
      apb(1'b1, USP_OFS_CTRL, 32'h00b);
      for (int k = 0; k < 2; k++) begin
         i_usp_remote_model.send_char(pat[k]);
         wait_bits(2);
         rd_chk(USP_OFS_RXDATA, 32'hff, 32'(pat[k]), "rx char");
      end
      $display("test receive done");
      apb(1'b1, USP_OFS_CTRL, 32'h00f);
      apb(1'b1, USP_OFS_TXDATA, 32'h5a);
      wait_bits(14);
      check("loop pin", i_usp_remote_model.got_cnt, 1);
      rd_chk(USP_OFS_RXDATA, 32'hff, 32'h5a, "loop char");
      $display("test loopback done");
      apb(1'b1, USP_OFS_CTRL, 32'h042);
      repeat (4) @(posedge i_core_clk);
      check("rts manual", {31'h0, rts_b}, 32'h0);
      apb(1'b1, USP_OFS_RTSLVL, 32'h1);
      apb(1'b1, USP_OFS_CTRL, 32'h202);
      repeat (4) @(posedge i_core_clk);
      check("rts room", {31'h0, rts_b}, 32'h0);
      i_usp_remote_model.send_char(8'h11);
      wait_bits(2);
      check("rts level", {31'h0, rts_b}, 32'h1);
      rd_chk(USP_OFS_RXDATA, 32'hff, 32'h11, "rts char");
      repeat (4) @(posedge i_core_clk);
      check("rts drained", {31'h0, rts_b}, 32'h0);
      $display("test flow control done");
      apb(1'b1, USP_OFS_CTRL, 32'h101);
      apb(1'b1, USP_OFS_TXDATA, 32'h69);
      repeat (4) @(posedge i_core_clk);
      check("rts tx busy", {31'h0, rts_b}, 32'h0);
      wait_bits(14);
      check("rts tx done", {31'h0, rts_b}, 32'h1);
      check("auto char", i_usp_remote_model.got_char, 32'h69);
      $display("test auto rts done");
      apb(1'b1, USP_OFS_CTRL, 32'h022);
      rd_chk(USP_OFS_STAT, 32'h40, 32'h40, "asleep");
      i_usp_remote_model.send_char(8'h00);
      wait_bits(2);
      rd_chk(USP_OFS_STAT, 32'h40, 32'h0, "awake");
      $display("test wake done");
      final_report();
   end
endmodule
bind usp_uart usp_uart_assertions i_usp_uart_assertions (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_prdata(o_prdata), .o_serial_tx_out(o_serial_tx_out),
   .i_serial_rx_in(i_serial_rx_in),
   .i_clear_to_send_in_b(i_clear_to_send_in_b),
   .o_request_to_send_out_b(o_request_to_send_out_b));
